//--- core/brc_config_four_resp_conv_ctrl.sv
`timescale 1ns/100ps
// How it works
// - codes 000/001 give 64k/32k modulation clock
// - codes 010..111 drive square waves on pins
// - pin four is pin three inverted whenever square waves drive the pins
// - codes 000/001 serve internal and external modes
// - internal mode with codes 000/001 drives modulation output terminals
// - bit 3 set selects single-shot conversion
// - bit 2 set joins terminal to leg drive
// - bit 1 set powers lead-off comparators
// - mode field decodes none/external/internal/user
// - phase applies only in those modes, codes
module brc_config_four_resp_conv_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [brc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [brc_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [brc_pkg::DATA_W-1:0] wb_dat_i,
  output logic [brc_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // device master clock, asynchronous to ref_clk
  input wire logic masterClk,
  // general pins three and four, split into in, out, enable
  input wire logic generalPinThreeIn,
  output logic generalPinThreeOut,
  output logic generalPinThreeOe,
  input wire logic generalPinFourIn,
  output logic generalPinFourOut,
  output logic generalPinFourOe,
  // modulation clock toward the breathing circuit
  output logic breathModClk,
  output logic breathModOutPos,
  output logic breathModOutNeg,
  // decoded controls toward the rest of the device
  output logic singleShotMode,
  output logic centralTerminalToLegDrive,
  output logic electrodeOffComparatorOn,
  output logic breathOff,
  output logic breathExternal,
  output logic breathInternalOwn,
  output logic breathInternalUser,
  output logic breathPhaseActive,
  output logic [brc_pkg::PHASE_W-1:0] breathPhase
);

  // register state
  logic [brc_pkg::REG_W-1:0] cfgFour; // config_four_resp_conv_ctrl
  logic [brc_pkg::REG_W-1:0] next_cfgFour;
  logic [brc_pkg::REG_W-1:0] modeReg; // breathing mode and phase
  logic [brc_pkg::REG_W-1:0] next_modeReg;
  logic ack; // single-cycle acknowledge
  logic next_ack;
  logic [brc_pkg::DATA_W-1:0] readData; // registered read word
  logic [brc_pkg::DATA_W-1:0] next_readData;

  // master clock sampling
  logic [2:0] pinSync; // synchronised master, pin three, pin four
  logic masterLevel; // master clock after the synchroniser
  logic masterPrev; // one cycle older, for edge detection
  logic masterTick; // one-cycle pulse per master rising edge
  logic [brc_pkg::DIV_STAGES-1:0] taps; // divided clocks

  // decoded fields
  logic [brc_pkg::FREQ_W-1:0] freqSel; // breath_mod_freq_sel
  brc_pkg::brc_mode_t modeSel; // breath_mode_sel
  logic [brc_pkg::PHASE_W-1:0] phaseSel; // breath_phase_sel
  logic isModCode; // frequency code names a modulation clock
  logic [3:0] tapIdx; // which counter bit carries the chosen rate
  logic chosenWave; // divided clock at the chosen rate
  logic phaseInForce; // phase selection takes effect
  logic busWrite; // accepted write beat this cycle
  logic busRead; // accepted read beat this cycle

  // output stage state
  logic modClkOut;
  logic next_modClkOut;
  logic modPos;
  logic next_modPos;
  logic modNeg;
  logic next_modNeg;
  logic pinThreeOut;
  logic next_pinThreeOut;
  logic pinFourOut;
  logic next_pinFourOut;
  logic pinOe;
  logic next_pinOe;

  // every asynchronous level passes two flops before use
  brc_sync #(
    .WIDTH(3)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn({generalPinFourIn, generalPinThreeIn, masterClk}),
    .syncOut(pinSync)
  );

  assign masterLevel = pinSync[0];

  // remember the previous master level for the edge detector
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      masterPrev <= 1'b0;
    end
    else
    begin
      masterPrev <= masterLevel;
    end
  end

  // at 40 MHz each master half period spans several samples, so no edge is missed
  assign masterTick = masterLevel & ~masterPrev;

  // one counter serves every rate, so all outputs stay phase related
  brc_divider #(
    .STAGES(brc_pkg::DIV_STAGES)
  ) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .masterTick(masterTick),
    .taps(taps)
  );

  // field extraction
  assign freqSel = cfgFour[brc_pkg::FREQ_LSB +: brc_pkg::FREQ_W];
  assign modeSel = brc_pkg::brc_mode_t'(modeReg[brc_pkg::MODE_LSB +: brc_pkg::MODE_W]);
  assign phaseSel = modeReg[brc_pkg::PHASE_LSB +: brc_pkg::PHASE_W];
  assign isModCode = (freqSel <= brc_pkg::FREQ_LAST_MOD);

  // code n takes counter bit 4+n: 000 divides by 32, 111 by 4096
  assign tapIdx = brc_pkg::TAP_BASE + {1'b0, freqSel};
  assign chosenWave = taps[tapIdx];

  // phase only counts in external or internal-own mode with a modulation code
  assign phaseInForce = isModCode
    && ((modeSel == brc_pkg::MODE_EXT) || (modeSel == brc_pkg::MODE_INT_OWN));

  // bus beat qualifiers; the ack term keeps one request to one beat
  assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ~ack;
  assign busRead = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;

  // register file next values and the answer to every access
  always_comb
  begin
    next_cfgFour = cfgFour;
    next_modeReg = modeReg;
    next_ack = wb_cyc_i & wb_stb_i & ~ack; // any address is answered
    next_readData = '0; // unmapped and idle reads give zero
    // only byte lane 0 carries register data
    if (busWrite && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        brc_pkg::CFG4_ADDR:
        begin
          // reserved bits are forced to zero whatever software sends
          next_cfgFour = wb_dat_i[brc_pkg::REG_W-1:0] & brc_pkg::CFG4_WMASK;
        end
        brc_pkg::MODE_ADDR:
        begin
          next_modeReg = wb_dat_i[brc_pkg::REG_W-1:0] & brc_pkg::MODE_WMASK;
        end
        default:
        begin
          // status and unmapped addresses ignore writes
          next_cfgFour = cfgFour;
        end
      endcase
    end
    if (busRead)
    begin
      unique case (wb_adr_i)
        brc_pkg::CFG4_ADDR:
        begin
          next_readData = {{(brc_pkg::DATA_W-brc_pkg::REG_W){1'b0}}, cfgFour};
        end
        brc_pkg::MODE_ADDR:
        begin
          next_readData = {{(brc_pkg::DATA_W-brc_pkg::REG_W){1'b0}}, modeReg};
        end
        brc_pkg::STAT_ADDR:
        begin
          next_readData[brc_pkg::ST_MODCLK] = modClkOut;
          next_readData[brc_pkg::ST_PIN3] = pinSync[1];
          next_readData[brc_pkg::ST_PIN4] = pinSync[2];
          next_readData[brc_pkg::ST_SQUARE] = pinOe;
          next_readData[brc_pkg::ST_PHASE] = phaseInForce;
          next_readData[brc_pkg::ST_MODOUT] = (modeSel == brc_pkg::MODE_INT_OWN) & isModCode;
        end
        default:
        begin
          next_readData = '0;
        end
      endcase
    end
  end

  // register file and bus answer flops
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfgFour <= brc_pkg::CFG4_RESET;
      modeReg <= brc_pkg::MODE_RESET;
      ack <= 1'b0;
      readData <= '0;
    end
    else
    begin
      cfgFour <= next_cfgFour;
      modeReg <= next_modeReg;
      ack <= next_ack;
      readData <= next_readData;
    end
  end

  // waveform steering from the chosen divided clock
  always_comb
  begin
    next_modClkOut = 1'b0;
    next_modPos = 1'b0;
    next_modNeg = 1'b0;
    next_pinThreeOut = 1'b0;
    next_pinFourOut = 1'b0;
    next_pinOe = 1'b0;
    if (isModCode)
    begin
      // 64 kHz or 32 kHz modulation clock, pins left free
      next_modClkOut = chosenWave;
      if (modeSel == brc_pkg::MODE_INT_OWN)
      begin
        // user-generated mode brings its own signals, so only this mode drives
        next_modPos = chosenWave;
        next_modNeg = ~chosenWave;
      end
    end
    else
    begin
      // square waves take over both general pins
      next_pinOe = 1'b1;
      next_pinThreeOut = chosenWave;
      next_pinFourOut = ~chosenWave;
    end
  end

  // output stage flops keep every pin glitch free
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      modClkOut <= 1'b0;
      modPos <= 1'b0;
      modNeg <= 1'b0;
      pinThreeOut <= 1'b0;
      pinFourOut <= 1'b0;
      pinOe <= 1'b0;
    end
    else
    begin
      modClkOut <= next_modClkOut;
      modPos <= next_modPos;
      modNeg <= next_modNeg;
      pinThreeOut <= next_pinThreeOut;
      pinFourOut <= next_pinFourOut;
      pinOe <= next_pinOe;
    end
  end

  // bus outputs
  assign wb_ack_o = ack;
  assign wb_dat_o = readData;

  // pin and clock outputs
  assign breathModClk = modClkOut;
  assign breathModOutPos = modPos;
  assign breathModOutNeg = modNeg;
  assign generalPinThreeOut = pinThreeOut;
  assign generalPinFourOut = pinFourOut;
  assign generalPinThreeOe = pinOe;
  assign generalPinFourOe = pinOe;

  // static controls come straight from register flops
  assign singleShotMode = cfgFour[brc_pkg::SINGLE_BIT];
  assign centralTerminalToLegDrive = cfgFour[brc_pkg::CT_BIT];
  assign electrodeOffComparatorOn = cfgFour[brc_pkg::LOFF_BIT];

  // mode decode, one line per encoding
  assign breathOff = (modeSel == brc_pkg::MODE_NONE);
  assign breathExternal = (modeSel == brc_pkg::MODE_EXT);
  assign breathInternalOwn = (modeSel == brc_pkg::MODE_INT_OWN);
  assign breathInternalUser = (modeSel == brc_pkg::MODE_INT_USER);

  // phase is passed on only while it applies; 111 names no phase
  assign breathPhaseActive = phaseInForce && (phaseSel != brc_pkg::PHASE_NONE);
  assign breathPhase = breathPhaseActive ? phaseSel : '0;

endmodule

//--- core/brc_pkg.sv
// shared constants for the breathing-clock configuration block
package brc_pkg;

  // register bus geometry
  localparam int ADDR_W = 8; // byte address width seen by the slave
  localparam int DATA_W = 32; // classic wishbone data width
  localparam int SEL_W = 4; // one select line per byte lane
  localparam int REG_W = 8; // every register here is one byte wide

  // register indices; byte address is four times the index
  localparam logic [5:0] CFG4_INDEX = 6'h17; // conversion and frequency control
  localparam logic [5:0] MODE_INDEX = 6'h16; // breathing mode and phase
  localparam logic [5:0] STAT_INDEX = 6'h1F; // live block state, read only
  localparam logic [ADDR_W-1:0] CFG4_ADDR = {CFG4_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] MODE_ADDR = {MODE_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_INDEX, 2'h0};

  // config_four_resp_conv_ctrl field layout
  localparam int FREQ_LSB = 5; // breath_mod_freq_sel occupies [7:5]
  localparam int FREQ_W = 3;
  localparam int SINGLE_BIT = 3; // single-shot conversion select
  localparam int CT_BIT = 2; // central_terminal_to_leg_drive
  localparam int LOFF_BIT = 1; // electrode_off_comparator_on
  localparam logic [REG_W-1:0] CFG4_RESET = 8'h00;
  localparam logic [REG_W-1:0] CFG4_WMASK = 8'hEE; // reserved bits 4 and 0 hold zero

  // breathing mode register field layout
  localparam int MODE_LSB = 0; // breath_mode_sel occupies [1:0]
  localparam int MODE_W = 2;
  localparam int PHASE_LSB = 2; // breath_phase_sel occupies [4:2]
  localparam int PHASE_W = 3;
  localparam logic [REG_W-1:0] MODE_RESET = 8'h00;
  localparam logic [REG_W-1:0] MODE_WMASK = 8'h1F;

  // status register bit positions
  localparam int ST_MODCLK = 0; // present modulation clock level
  localparam int ST_PIN3 = 1; // synchronised level of general pin three
  localparam int ST_PIN4 = 2; // synchronised level of general pin four
  localparam int ST_SQUARE = 3; // square waves are being driven
  localparam int ST_PHASE = 4; // phase selection is in force
  localparam int ST_MODOUT = 5; // modulation terminals are active

  // breathing mode encodings
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_EXT = 2'h1,
    MODE_INT_OWN = 2'h2,
    MODE_INT_USER = 2'h3
  } brc_mode_t;

  // frequency codes at or below this one are modulation clocks
  localparam logic [FREQ_W-1:0] FREQ_LAST_MOD = 3'h1;
  // phase code that names no phase
  localparam logic [PHASE_W-1:0] PHASE_NONE = 3'h7;

  // master clock divider: code 000 divides by 32, code 111 by 4096
  localparam int MASTER_CLK_KHZ = 2048; // nominal master clock
  localparam int DIV_STAGES = 12; // counter bits, top bit divides by 4096
  localparam logic [3:0] TAP_BASE = 4'h4; // counter bit 4 toggles at master/32

  // sampling margin: master half period against the 25 ns system period
  localparam int REF_CLK_MHZ = 40;
  localparam int MASTER_HALF_NS = 244; // half period of 2.048 MHz, rounded down
  localparam int REF_PERIOD_NS = 1000 / REF_CLK_MHZ;
  localparam int MASTER_HALF_CYC = MASTER_HALF_NS / REF_PERIOD_NS; // at least 1

  // synchroniser depth for every asynchronous input
  localparam int SYNC_DEPTH = 2;

endpackage

//--- core/brc_sync.sv
`timescale 1ns/100ps
// two flip-flop synchroniser, one chain per bit
module brc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < WIDTH; bitIdx++)
    begin : g_chain
      logic [brc_pkg::SYNC_DEPTH-1:0] stage; // stage[0] feeds only stage[1]
      // shift the pin level through the chain
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          stage <= '0;
        end
        else
        begin
          stage <= {stage[brc_pkg::SYNC_DEPTH-2:0], asyncIn[bitIdx]};
        end
      end
      assign syncOut[bitIdx] = stage[brc_pkg::SYNC_DEPTH-1];
    end
  endgenerate

endmodule

//--- core/brc_divider.sv
`timescale 1ns/100ps
// free-running counter of master clock ticks; each bit is a divided clock
module brc_divider #(
  parameter int STAGES = brc_pkg::DIV_STAGES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic masterTick,
  output logic [STAGES-1:0] taps
);

  logic [STAGES-1:0] count; // master ticks seen so far
  logic [STAGES-1:0] next_count;

  // bit k completes a period every 2^(k+1) ticks
  always_comb
  begin
    next_count = count;
    if (masterTick)
    begin
      next_count = count + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

  // register the counter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign taps = count;

endmodule

//--- verification/brc_config_four_resp_conv_ctrl_chk.sv
`timescale 1ns/100ps
// port-level watcher for the breathing-clock config block
module brc_config_four_resp_conv_ctrl_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [brc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [brc_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [brc_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [brc_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic generalPinThreeOut,
  input wire logic generalPinThreeOe,
  input wire logic generalPinFourOut,
  input wire logic generalPinFourOe,
  input wire logic breathModClk,
  input wire logic breathModOutPos,
  input wire logic breathModOutNeg,
  input wire logic singleShotMode,
  input wire logic centralTerminalToLegDrive,
  input wire logic electrodeOffComparatorOn,
  input wire logic breathOff,
  input wire logic breathExternal,
  input wire logic breathInternalOwn,
  input wire logic breathInternalUser,
  input wire logic breathPhaseActive,
  input wire logic [brc_pkg::PHASE_W-1:0] breathPhase
);
  // config write or read, seen in its ack cycle while the master still holds it
  logic cfgWr;
  logic cfgRd;
  assign cfgWr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == brc_pkg::CFG4_ADDR;
  assign cfgRd = wb_ack_o && !wb_we_i && wb_adr_i == brc_pkg::CFG4_ADDR;
  default clocking cb @(posedge ref_clk);
  endclocking
  // nothing is judged while reset holds everything at zero
  default disable iff (rst);
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_quick_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  single_shot_a: assert property (cfgWr |-> singleShotMode == wb_dat_i[3])
    else $error("single-shot output wrong after write");
  leg_drive_a: assert property (cfgWr |-> centralTerminalToLegDrive == wb_dat_i[2])
    else $error("leg drive link wrong after write");
  comp_on_a: assert property (cfgWr |-> electrodeOffComparatorOn == wb_dat_i[1])
    else $error("comparator enable wrong after write");
  cfg_read_a: assert property (cfgRd |-> wb_dat_o[4:3] == {1'b0, singleShotMode})
    else $error("config read data wrong");
  pin_inverse_a: assert property (generalPinThreeOe |-> generalPinFourOut != generalPinThreeOut)
    else $error("pin four not inverse of pin three");
  square_quiet_a: assert property (generalPinThreeOe [*2] |-> !breathModClk && generalPinFourOe)
    else $error("square wave and modulation clock together");
  mode_onehot_a: assert property
    ($onehot({breathOff, breathExternal, breathInternalOwn, breathInternalUser}))
    else $error("mode decode not one-hot");
  phase_gate_a: assert property ((breathOff || breathInternalUser) [*2] |-> !breathPhaseActive)
    else $error("phase in force outside its modes");
  modout_gate_a: assert property (!breathInternalOwn [*2] |-> !breathModOutPos && !breathModOutNeg)
    else $error("modulation terminals active outside internal mode");
  cover property (cfgWr);
  cover property (generalPinThreeOe && generalPinThreeOut);
  cover property (breathPhaseActive && breathModOutPos);
endmodule
bind brc_config_four_resp_conv_ctrl brc_config_four_resp_conv_ctrl_chk brc_config_four_resp_conv_ctrl_chk_i (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .generalPinThreeOut,
  .generalPinThreeOe, .generalPinFourOut, .generalPinFourOe, .breathModClk, .breathModOutPos,
  .breathModOutNeg, .singleShotMode, .centralTerminalToLegDrive, .electrodeOffComparatorOn,
  .breathOff, .breathExternal, .breathInternalOwn, .breathInternalUser, .breathPhaseActive,
  .breathPhase);

//--- verification/test_brc_config_four_resp_conv_ctrl.sv
`timescale 1ns/100ps
// self-checking bench for the breathing-clock config block
module test_brc_config_four_resp_conv_ctrl;
  // design inputs
  logic ref_clk, rst, masterClk, wb_cyc_i, wb_stb_i, wb_we_i;
  logic generalPinThreeIn, generalPinFourIn;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  // design outputs
  logic [31:0] wb_dat_o;
  logic wb_ack_o, generalPinThreeOut, generalPinThreeOe, generalPinFourOut, generalPinFourOe;
  logic breathModClk, breathModOutPos, breathModOutNeg, singleShotMode;
  logic centralTerminalToLegDrive, electrodeOffComparatorOn, breathOff, breathExternal;
  logic breathInternalOwn, breathInternalUser, breathPhaseActive;
  logic [2:0] breathPhase;
  // tallies and last read word
  int num_errors = 0;
  int checks = 0;
  logic [31:0] rd;

  brc_config_four_resp_conv_ctrl brc_config_four_resp_conv_ctrl_i (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .masterClk, .generalPinThreeIn,
    .generalPinThreeOut, .generalPinThreeOe, .generalPinFourIn, .generalPinFourOut,
    .generalPinFourOe, .breathModClk, .breathModOutPos, .breathModOutNeg, .singleShotMode,
    .centralTerminalToLegDrive, .electrodeOffComparatorOn, .breathOff, .breathExternal,
    .breathInternalOwn, .breathInternalUser, .breathPhaseActive, .breathPhase);

  // 40 MHz system clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // master clock, offset so its edges drift against ref_clk
  initial
  begin
    masterClk = 1'b0;
    #3.3;
    forever #244.1 masterClk = ~masterClk;
  end

  task automatic finish_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one classic cycle; the ack wait is bounded so a dead slave ends the run
  task automatic bus(input logic [7:0] a, input logic we, input logic [7:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    // judge the answer itself, so an ack on the last allowed edge still counts
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      finish_test();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  // reset values, each control bit alone, masked lane and unmapped read
  task automatic t_bits();
    logic [7:0] pat[5] = '{8'h08, 8'h04, 8'h02, 8'hEE, 8'h00};
    logic [2:0] ctl;
    bus(brc_pkg::CFG4_ADDR, 1'b0, 8'h00, 4'hF);
    check(rd, {24'h0, brc_pkg::CFG4_RESET});
    bus(brc_pkg::MODE_ADDR, 1'b0, 8'h00, 4'hF);
    check(rd, {24'h0, brc_pkg::MODE_RESET});
    foreach (pat[i])
    begin
      bus(brc_pkg::CFG4_ADDR, 1'b1, pat[i], 4'h1);
      bus(brc_pkg::CFG4_ADDR, 1'b0, 8'h00, 4'hF);
      check(rd, {24'h0, pat[i] & 8'hEE});
      ctl = {singleShotMode, centralTerminalToLegDrive, electrodeOffComparatorOn};
      check(32'(ctl), 32'(pat[i][3:1]));
    end
    bus(brc_pkg::CFG4_ADDR, 1'b1, 8'hEE, 4'hE);
    bus(brc_pkg::CFG4_ADDR, 1'b0, 8'h00, 4'hF);
    check(rd, 32'h0);
    bus(8'h40, 1'b0, 8'h00, 4'hF);
    check(rd, 32'h0);
  endtask

  // every mode decoded, phase gating, terminals in internal mode
  task automatic t_modes();
    int n;
    logic [3:0] dec;
    for (int m = 0; m < 4; m++)
    begin
      bus(brc_pkg::MODE_ADDR, 1'b1, {3'h0, 3'h3, m[1:0]}, 4'h1);
      repeat (2) @(posedge ref_clk);
      dec = {breathInternalUser, breathInternalOwn, breathExternal, breathOff};
      check(32'(dec), 32'h1 << m);
      check(32'({breathPhaseActive, breathPhase}), (m == 1 || m == 2) ? 32'hB : 32'h0);
    end
    bus(brc_pkg::MODE_ADDR, 1'b1, 8'h02, 4'h1);
    n = 0;
    // wait for a fresh rising edge, so the check below is far from the next toggle
    while (breathModOutPos !== 1'b0 && n < 800)
    begin
      @(posedge ref_clk);
      n++;
    end
    while (breathModOutPos !== 1'b1 && n < 800)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (breathModOutPos !== 1'b1)
    begin
      num_errors++;
      finish_test();
    end
    repeat (2) @(posedge ref_clk);
    check(32'({breathModOutPos, breathModOutNeg, breathModClk}), 32'h5);
    bus(brc_pkg::MODE_ADDR, 1'b1, 8'h1E, 4'h1);
    repeat (2) @(posedge ref_clk);
    check(32'(breathPhaseActive), 32'h0);
  endtask

  // the waveform that carries the chosen frequency
  function automatic logic wave(input int c);
    return c < 2 ? breathModClk : generalPinThreeOut;
  endfunction

  // every frequency code in external mode: which pins run; half-period length for codes below 6
  task automatic t_freq();
    int n;
    int len;
    logic prev;
    logic [2:0] seen3;
    bus(brc_pkg::MODE_ADDR, 1'b1, 8'h01, 4'h1);
    for (int c = 0; c < 8; c++)
    begin
      bus(brc_pkg::CFG4_ADDR, 1'b1, 8'(c << 5), 4'h1);
      repeat (3) @(posedge ref_clk);
      seen3 = {generalPinThreeOe, generalPinFourOe, breathPhaseActive};
      check(32'(seen3), c > 1 ? 32'h6 : 32'h1);
      // the two slowest codes would blow the run length, so only their pins are checked
      if (c < 6)
      begin
        for (int h = 0; h < 2; h++)
        begin
          n = 0;
          prev = wave(c);
          while (wave(c) === prev && n < 50000)
          begin
            @(posedge ref_clk);
            n++;
          end
          // a wave that never toggles is a dead divider, not a long wait
          if (wave(c) === prev)
          begin
            num_errors++;
            finish_test();
          end
          len = n;
        end
        check(32'(len > 312 * (1 << c) - 4 && len < 313 * (1 << c) + 4), 32'h1);
      end
    end
  endtask

  // pin inputs and square-wave flag through the status word
  task automatic t_pins();
    generalPinThreeIn <= 1'b1;
    generalPinFourIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus(brc_pkg::STAT_ADDR, 1'b0, 8'h00, 4'hF);
    check(32'(rd[3:1]), 32'h5);
  endtask

  initial
  begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    generalPinThreeIn = 1'b0;
    generalPinFourIn = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_bits();
    t_modes();
    t_freq();
    t_pins();
    finish_test();
  end
endmodule
